//--- rtl/rdr_cfg_ctrl.sv
// What this block does
// - mode high: strap state, register writes rejected
// - mode low: host may rewrite registers
// - mode level gates writes live, unlatched
// - straps captured into registers at power-on
// - power-down low disables whole device
// - channel reset low holds detection reset
// - group enables steer A and B detection
// - one equalizer field per channel group
// - three-bit equalizer code, rising boost
// - swing and de-emphasis held per group
// - two-bit swing code per group
// - three-bit de-emphasis code per group
// - half-bit default, full-bit after control rewrite
// - de-emphasis independent of data rate
// - quiet input squelches channel output
// - I2C slave, seven-bit address, three pin bits
// - bytes sequential from lowest, stop anytime
// - detection starts on channel reset rising
`default_nettype none
module rdr_cfg_ctrl
    import rdr_cfg_pkg::*;
#(
    // arbitrary neutral value for the fixed address bits
    parameter logic [6:0] I2C_ADDR_BASE = 7'h20
)
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    input wire logic [2:0] addr_pins,
    input wire logic mode_sel,
    input wire logic power_down_n,
    input wire logic loopback_n,
    input wire logic chan_reset_n,
    input wire logic rxd_en_a,
    input wire logic rxd_en_b,
    input wire logic [7:0] sig_detect,
    input wire logic [7:0] rx50_result,
    output logic device_enable,
    output logic loopback_n_cfg,
    output logic [2:0] eq_level_code_a,
    output logic [2:0] eq_level_code_b,
    output logic [1:0] swing_code_a,
    output logic [1:0] swing_code_b,
    output logic [2:0] deemph_code_a,
    output logic [2:0] deemph_code_b,
    output logic full_bit_deemph,
    output logic [7:0] input_disable,
    output logic [7:0] detect_en,
    output logic [7:0] detect_reset,
    output logic detect_start,
    output logic [7:0] tx_drive_en
);
    // ==================================================
    // pin synchronisers
    logic [PIN_COUNT-1:0] pin_raw, meta_q, sync_q;
    assign pin_raw = {addr_pins, sig_detect, rxd_en_b, rxd_en_a, chan_reset_n,
                      loopback_n, power_down_n, mode_sel};
    for (genvar i = 0; i < PIN_COUNT; i++)
    begin : g_sync
        always_ff @(posedge clk or negedge rst_b)
        begin
            if (!rst_b)
            begin
                meta_q[i] <= 1'b0;
                sync_q[i] <= 1'b0;
            end
            else
            begin
                meta_q[i] <= pin_raw[i];
                sync_q[i] <= meta_q[i];
            end
        end
    end
    logic mode_s, pd_s, lb_s, rst_s, rxa_s, rxb_s;
    logic [7:0] sig_s;
    logic [2:0] apin_s;
    assign mode_s = sync_q[PIN_MODE];
    assign pd_s = sync_q[PIN_PD];
    assign lb_s = sync_q[PIN_LB];
    assign rst_s = sync_q[PIN_RST];
    assign rxa_s = sync_q[PIN_RXDA];
    assign rxb_s = sync_q[PIN_RXDB];
    assign sig_s = sync_q[PIN_SIG +: 8];
    assign apin_s = sync_q[PIN_ADDR +: 3];
    // ==================================================
    // register port
    logic wr_stb;
    logic [2:0] byte_idx;
    logic [7:0] wr_data, rd_data;
    logic [6:0] dev_addr;
    logic sda_oe_raw;
    assign dev_addr = {I2C_ADDR_BASE[6:5], apin_s[2], I2C_ADDR_BASE[3:2], apin_s[1:0]};
    rdr_i2c_slave u_i2c (
        .clk(clk),
        .rst_b(rst_b),
        .scl_i(scl_i),
        .sda_i(sda_i),
        .enable(pd_s),
        .dev_addr(dev_addr),
        .rd_data(rd_data),
        .sda_oe(sda_oe_raw),
        .wr_stb(wr_stb),
        .byte_idx(byte_idx),
        .wr_data(wr_data)
    );
    assign sda_o = 1'b0;
    assign sda_oe = sda_oe_raw & pd_s;
    // no clock stretching, so scl is never driven
    assign scl_o = 1'b0;
    assign scl_oe = 1'b0;
    // ==================================================
    // configuration registers
    logic [1:0] strap_cnt_q, strap_cnt_d;
    logic strap_done_q, strap_done_d, capture, wr_ok;
    logic [7:0] loop_emph_q, loop_emph_d, indis_q, indis_d;
    logic [5:0] eq_q, eq_d, deemph_q, deemph_d;
    logic [3:0] swing_q, swing_d;
    logic [2:0] misc_q, misc_d;
    logic full_bit_q, full_bit_d;
    // writes look at the live synchronised mode level every cycle
    assign wr_ok = wr_stb & ~mode_s & strap_done_q;
    // straps are caught after release, once the synchronisers hold pin levels
    assign capture = ~strap_done_q & (strap_cnt_q == STRAP_WAIT);
    always_comb
    begin
        strap_cnt_d = strap_done_q ? strap_cnt_q : strap_cnt_q + 2'h1;
        strap_done_d = strap_done_q | capture;
        loop_emph_d = loop_emph_q;
        indis_d = indis_q;
        eq_d = eq_q;
        swing_d = swing_q;
        deemph_d = deemph_q;
        misc_d = misc_q;
        full_bit_d = full_bit_q | (wr_ok & (byte_idx == IDX_LOOP_EMPH));
        if (capture)
        begin
            loop_emph_d[LOOP_EMPH_LB_BIT] = lb_s;
            misc_d = {rxb_s, rxa_s, rst_s};
        end
        if (wr_ok)
        begin
            case (byte_idx)
                IDX_LOOP_EMPH: loop_emph_d = wr_data;
                IDX_INDIS: indis_d = wr_data;
                IDX_EQ: eq_d = wr_data[5:0];
                IDX_SWING: swing_d = wr_data[3:0];
                IDX_DEEMPH: deemph_d = wr_data[5:0];
                IDX_MISC: misc_d = wr_data[2:0];
                default: ;
            endcase
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            strap_cnt_q <= 2'h0;
            strap_done_q <= 1'b0;
            loop_emph_q <= LOOP_EMPH_RST;
            indis_q <= INDIS_RST;
            eq_q <= EQ_RST;
            swing_q <= SWING_RST;
            deemph_q <= DEEMPH_RST;
            misc_q <= MISC_RST;
            full_bit_q <= 1'b0;
        end
        else
        begin
            strap_cnt_q <= strap_cnt_d;
            strap_done_q <= strap_done_d;
            loop_emph_q <= loop_emph_d;
            indis_q <= indis_d;
            eq_q <= eq_d;
            swing_q <= swing_d;
            deemph_q <= deemph_d;
            misc_q <= misc_d;
            full_bit_q <= full_bit_d;
        end
    end
    always_comb
    begin
        case (byte_idx)
            IDX_SIG: rd_data = sig_s;
            IDX_RX50: rd_data = rx50_result;
            IDX_LOOP_EMPH: rd_data = loop_emph_q;
            IDX_INDIS: rd_data = indis_q;
            IDX_EQ: rd_data = {2'h0, eq_q};
            IDX_SWING: rd_data = {4'h0, swing_q};
            IDX_DEEMPH: rd_data = {2'h0, deemph_q};
            IDX_MISC: rd_data = {5'h00, misc_q};
            default: rd_data = 8'h00;
        endcase
    end
    // codes pass through untouched; the analog side maps them to levels
    assign eq_level_code_a = eq_q[2:0];
    assign eq_level_code_b = eq_q[5:3];
    assign swing_code_a = swing_q[1:0];
    assign swing_code_b = swing_q[3:2];
    assign deemph_code_a = deemph_q[2:0];
    assign deemph_code_b = deemph_q[5:3];
    assign full_bit_deemph = full_bit_q;
    assign loopback_n_cfg = loop_emph_q[LOOP_EMPH_LB_BIT];
    assign input_disable = indis_q;
    // ==================================================
    // channel control outputs
    logic eff_rst_n, eff_prev_q, dev_en_q, start_q;
    logic [7:0] det_en_q, det_en_d, det_rst_q, tx_en_q, tx_en_d;
    assign eff_rst_n = rst_s & misc_q[MISC_RST_BIT] & pd_s;
    always_comb
    begin
        det_en_d = {{4{misc_q[MISC_RXDB_BIT]}}, {4{misc_q[MISC_RXDA_BIT]}}} & {8{pd_s}};
        tx_en_d = {8{pd_s}} & sig_s & ~indis_q;
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            eff_prev_q <= 1'b0;
            dev_en_q <= 1'b0;
            start_q <= 1'b0;
            det_en_q <= 8'h00;
            det_rst_q <= 8'hff;
            tx_en_q <= 8'h00;
        end
        else
        begin
            eff_prev_q <= eff_rst_n;
            dev_en_q <= pd_s;
            start_q <= eff_rst_n & ~eff_prev_q;
            det_en_q <= det_en_d;
            det_rst_q <= {8{~eff_rst_n}};
            tx_en_q <= tx_en_d;
        end
    end
    assign device_enable = dev_en_q;
    assign detect_en = det_en_q;
    assign detect_reset = det_rst_q;
    assign detect_start = start_q;
    assign tx_drive_en = tx_en_q;
    // ==================================================
    // assertions
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_b);
    sequence s_loop_emph_write;
        wr_ok && byte_idx == IDX_LOOP_EMPH;
    endsequence
    sequence s_rst_release;
        !eff_rst_n ##1 eff_rst_n;
    endsequence
    property p_mode_blocks;
        (wr_stb && mode_s) |=> $stable(eq_q) && $stable(swing_q) && $stable(deemph_q);
    endproperty
    a_mode_blocks: assert property (p_mode_blocks) else $error("write taken in pin mode");
    property p_write_eq;
        (wr_stb && !mode_s && strap_done_q && byte_idx == IDX_EQ)
            |=> eq_q == $past(wr_data[5:0]);
    endproperty
    a_write_eq: assert property (p_write_eq) else $error("eq write lost");
    property p_mode_live;
        (wr_stb && !mode_s && strap_done_q && byte_idx == IDX_SWING)
            |=> swing_q == $past(wr_data[3:0]);
    endproperty
    a_mode_live: assert property (p_mode_live) else $error("swing write lost");
    property p_strap;
        $rose(strap_done_q) |-> loop_emph_q[LOOP_EMPH_LB_BIT] == $past(lb_s, 1)
            && misc_q == $past({rxb_s, rxa_s, rst_s}, 1);
    endproperty
    a_strap: assert property (p_strap) else $error("strap not captured");
    property p_power_down;
        !pd_s |=> !device_enable && tx_drive_en == 8'h00 && detect_en == 8'h00;
    endproperty
    a_power_down: assert property (p_power_down) else $error("active in power down");
    property p_chan_reset;
        !rst_s |=> detect_reset == 8'hff && !detect_start;
    endproperty
    a_chan_reset: assert property (p_chan_reset) else $error("detect not held reset");
    property p_group_en;
        pd_s |=> detect_en[3:0] == {4{$past(misc_q[MISC_RXDA_BIT])}}
            && detect_en[7:4] == {4{$past(misc_q[MISC_RXDB_BIT])}};
    endproperty
    a_group_en: assert property (p_group_en) else $error("group enable wrong");
    property p_full_bit;
        s_loop_emph_write |=> full_bit_deemph ##1 full_bit_deemph;
    endproperty
    a_full_bit: assert property (p_full_bit) else $error("full-bit not set");
    property p_squelch;
        (!sig_s[0] || !pd_s) |=> !tx_drive_en[0];
    endproperty
    a_squelch: assert property (p_squelch) else $error("quiet channel drives");
    property p_detect_start;
        s_rst_release |=> detect_start ##1 !detect_start;
    endproperty
    a_detect_start: assert property (p_detect_start) else $error("no detect start");
endmodule
`default_nettype wire

//--- rtl/rdr_cfg_pkg.sv
`default_nettype none
package rdr_cfg_pkg;
    // ==================================================
    // register byte indices, walked in order by the host
    localparam logic [2:0] IDX_SIG = 3'h0;
    localparam logic [2:0] IDX_RX50 = 3'h1;
    localparam logic [2:0] IDX_LOOP_EMPH = 3'h2;
    localparam logic [2:0] IDX_INDIS = 3'h3;
    localparam logic [2:0] IDX_EQ = 3'h4;
    localparam logic [2:0] IDX_SWING = 3'h5;
    localparam logic [2:0] IDX_DEEMPH = 3'h6;
    localparam logic [2:0] IDX_MISC = 3'h7;
    // ==================================================
    // field positions
    localparam int unsigned LOOP_EMPH_LB_BIT = 0;
    localparam int unsigned MISC_RST_BIT = 0;
    localparam int unsigned MISC_RXDA_BIT = 1;
    localparam int unsigned MISC_RXDB_BIT = 2;
    localparam int unsigned PIN_MODE = 0;
    localparam int unsigned PIN_PD = 1;
    localparam int unsigned PIN_LB = 2;
    localparam int unsigned PIN_RST = 3;
    localparam int unsigned PIN_RXDA = 4;
    localparam int unsigned PIN_RXDB = 5;
    localparam int unsigned PIN_SIG = 6;
    localparam int unsigned PIN_ADDR = 14;
    localparam int unsigned PIN_COUNT = 17;
    // ==================================================
    // power-on values: group A in the low field, group B in the high field
    localparam logic [7:0] LOOP_EMPH_RST = 8'h01;
    localparam logic [7:0] INDIS_RST = 8'h00;
    localparam logic [5:0] EQ_RST = 6'h1b;
    localparam logic [3:0] SWING_RST = 4'h0;
    localparam logic [5:0] DEEMPH_RST = 6'h09;
    localparam logic [2:0] MISC_RST = 3'h7;
    // ==================================================
    // timing: edges after reset release before the synchronised straps are valid
    localparam logic [1:0] STRAP_WAIT = 2'h3;
    localparam logic [3:0] BITS_PER_BYTE = 4'h8;
    localparam logic [3:0] LAST_RD_BIT = 4'h7;
    // ==================================================
    typedef enum logic [2:0] {
        ST_IDLE = 3'h0,
        ST_ADDR = 3'h1,
        ST_AACK = 3'h2,
        ST_WDATA = 3'h3,
        ST_RDATA = 3'h4,
        ST_RACK = 3'h5,
        ST_RLOAD = 3'h6,
        ST_WACK = 3'h7
    } rdr_i2c_state_t;
endpackage
`default_nettype wire

//--- rtl/rdr_i2c_slave.sv
`default_nettype none
module rdr_i2c_slave
    import rdr_cfg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic scl_i,
    input wire logic sda_i,
    input wire logic enable,
    input wire logic [6:0] dev_addr,
    input wire logic [7:0] rd_data,
    output logic sda_oe,
    output logic wr_stb,
    output logic [2:0] byte_idx,
    output logic [7:0] wr_data
);
    // ==================================================
    // synchronisers; stage 0 is only read by stage 1
    logic [2:0] scl_q;
    logic [2:0] sda_q;
    logic scl_rise, scl_fall, start_c, stop_c;
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            scl_q <= 3'h7;
            sda_q <= 3'h7;
        end
        else
        begin
            scl_q <= {scl_q[1:0], scl_i};
            sda_q <= {sda_q[1:0], sda_i};
        end
    end
    assign scl_rise = scl_q[1] & ~scl_q[2];
    assign scl_fall = ~scl_q[1] & scl_q[2];
    assign start_c = scl_q[1] & scl_q[2] & sda_q[2] & ~sda_q[1];
    assign stop_c = scl_q[1] & scl_q[2] & ~sda_q[2] & sda_q[1];
    // ==================================================
    // byte engine: seven-bit address, transfers always start at byte 0
    rdr_i2c_state_t state_q, state_d;
    logic [3:0] cnt_q, cnt_d;
    logic [7:0] sh_q, sh_d;
    logic [2:0] idx_q, idx_d;
    logic oe_q, oe_d, rw_q, rw_d, wr_q, wr_d;
    always_comb
    begin
        state_d = state_q;
        cnt_d = cnt_q;
        sh_d = sh_q;
        idx_d = idx_q;
        oe_d = oe_q;
        rw_d = rw_q;
        wr_d = 1'b0;
        case (state_q)
            ST_IDLE: ;
            ST_ADDR:
            begin
                if (scl_rise)
                begin
                    sh_d = {sh_q[6:0], sda_q[1]};
                    cnt_d = cnt_q + 4'h1;
                end
                else if (scl_fall && cnt_q == BITS_PER_BYTE)
                begin
                    if (sh_q[7:1] == dev_addr)
                    begin
                        oe_d = 1'b1;
                        rw_d = sh_q[0];
                        idx_d = 3'h0;
                        state_d = ST_AACK;
                    end
                    else
                        state_d = ST_IDLE;
                end
            end
            ST_AACK:
            begin
                if (scl_fall)
                begin
                    cnt_d = 4'h0;
                    if (rw_q)
                    begin
                        sh_d = rd_data;
                        oe_d = ~rd_data[7];
                        state_d = ST_RDATA;
                    end
                    else
                    begin
                        oe_d = 1'b0;
                        state_d = ST_WDATA;
                    end
                end
            end
            ST_WDATA:
            begin
                if (scl_rise)
                begin
                    sh_d = {sh_q[6:0], sda_q[1]};
                    cnt_d = cnt_q + 4'h1;
                end
                else if (scl_fall && cnt_q == BITS_PER_BYTE)
                begin
                    wr_d = 1'b1;
                    oe_d = 1'b1;
                    state_d = ST_WACK;
                end
            end
            ST_WACK:
            begin
                if (scl_fall)
                begin
                    oe_d = 1'b0;
                    cnt_d = 4'h0;
                    idx_d = idx_q + 3'h1;
                    state_d = ST_WDATA;
                end
            end
            ST_RDATA:
            begin
                if (scl_fall)
                begin
                    if (cnt_q == LAST_RD_BIT)
                    begin
                        oe_d = 1'b0;
                        idx_d = idx_q + 3'h1;
                        state_d = ST_RACK;
                    end
                    else
                    begin
                        cnt_d = cnt_q + 4'h1;
                        sh_d = {sh_q[6:0], 1'b0};
                        oe_d = ~sh_q[6];
                    end
                end
            end
            ST_RACK:
            begin
                if (scl_rise)
                    state_d = sda_q[1] ? ST_IDLE : ST_RLOAD;
            end
            ST_RLOAD:
            begin
                if (scl_fall)
                begin
                    sh_d = rd_data;
                    oe_d = ~rd_data[7];
                    cnt_d = 4'h0;
                    state_d = ST_RDATA;
                end
            end
            default: state_d = ST_IDLE;
        endcase
        if (start_c)
        begin
            state_d = ST_ADDR;
            cnt_d = 4'h0;
            oe_d = 1'b0;
        end
        // a stop may come after any whole byte
        if (stop_c || !enable)
        begin
            state_d = ST_IDLE;
            oe_d = 1'b0;
        end
    end
    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 4'h0;
            sh_q <= 8'h00;
            idx_q <= 3'h0;
            oe_q <= 1'b0;
            rw_q <= 1'b0;
            wr_q <= 1'b0;
        end
        else
        begin
            state_q <= state_d;
            cnt_q <= cnt_d;
            sh_q <= sh_d;
            idx_q <= idx_d;
            oe_q <= oe_d;
            rw_q <= rw_d;
            wr_q <= wr_d;
        end
    end
    assign sda_oe = oe_q;
    assign wr_stb = wr_q;
    assign byte_idx = idx_q;
    assign wr_data = sh_q;
endmodule
`default_nettype wire

//--- tb/rdr_i2c_host_model.sv
`default_nettype none
module rdr_i2c_host_model
#(
    parameter int QTR_NS = 100
)
(
    output logic scl,
    output logic sda_low,
    input wire logic sda_line
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] buf_q [8];
    logic ack_ok;
    initial
    begin
        scl = 1'b1;
        sda_low = 1'b0;
    end
    // ==================================================
    // bus phases
    task automatic bit_c(input logic b, output logic s);
        sda_low = ~b;
        #QTR_NS scl = 1'b1;
        #QTR_NS s = sda_line;
        #QTR_NS scl = 1'b0;
        #QTR_NS;
    endtask
    task automatic byte_c(input logic [7:0] d, output logic [7:0] r);
        for (int i = 7; i >= 0; i--)
            bit_c(d[i], r[i]);
    endtask
    // ==================================================
    // one transfer; data released to the pull-up while reading
    task automatic xfer(input logic [6:0] a, input logic rd, input int n);
        logic s;
        logic [7:0] r;
        sda_low = 1'b0;
        #QTR_NS sda_low = 1'b1;
        #QTR_NS scl = 1'b0;
        #QTR_NS byte_c({a, rd}, r);
        bit_c(1'b1, s);
        ack_ok = ~s;
        for (int i = 0; i < n && ack_ok; i++)
        begin
            byte_c(rd ? 8'hff : buf_q[i], r);
            bit_c(rd ? (i == n - 1) : 1'b1, s);
            if (rd)
                buf_q[i] = r;
        end
        sda_low = 1'b1;
        #QTR_NS scl = 1'b1;
        #QTR_NS sda_low = 1'b0;
        #(2 * QTR_NS);
    endtask
endmodule
`default_nettype wire

//--- tb/tb.sv
`default_nettype none
module tb
    import rdr_cfg_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    // address pins 101 on the fixed base bits
    localparam logic [6:0] DEV_ADDR = 7'h31;
    logic clk = 1'b0, rst_b = 1'b0, scl, host_low, sda, mode_sel = 1'b1;
    logic power_down_n = 1'b1, loopback_n = 1'b0, chan_reset_n = 1'b1;
    logic rxd_en_a = 1'b1, rxd_en_b = 1'b0;
    logic [7:0] sig_detect = 8'h00, rx50_result = 8'h00;
    logic sda_oe, device_enable, loopback_n_cfg, full_bit_deemph, detect_start;
    logic [2:0] eq_a, eq_b, de_a, de_b;
    logic [1:0] sw_a, sw_b;
    logic [7:0] input_disable, detect_en, detect_reset, tx_drive_en;
    int miscompares = 0, num_checks = 0, cyc = 0;
    assign sda = ~(host_low | sda_oe);
    always #2.5 clk = ~clk;
    rdr_i2c_host_model host_u (.scl(scl), .sda_low(host_low), .sda_line(sda));
    rdr_cfg_ctrl dut_u (.clk(clk), .rst_b(rst_b), .scl_i(scl), .scl_o(), .scl_oe(),
        .sda_i(sda), .sda_o(), .sda_oe(sda_oe), .addr_pins(3'h5), .mode_sel(mode_sel),
        .power_down_n(power_down_n), .loopback_n(loopback_n), .chan_reset_n(chan_reset_n),
        .rxd_en_a(rxd_en_a), .rxd_en_b(rxd_en_b), .sig_detect(sig_detect),
        .rx50_result(rx50_result), .device_enable(device_enable),
        .loopback_n_cfg(loopback_n_cfg), .eq_level_code_a(eq_a), .eq_level_code_b(eq_b),
        .swing_code_a(sw_a), .swing_code_b(sw_b), .deemph_code_a(de_a),
        .deemph_code_b(de_b), .full_bit_deemph(full_bit_deemph),
        .input_disable(input_disable), .detect_en(detect_en), .detect_reset(detect_reset),
        .detect_start(detect_start), .tx_drive_en(tx_drive_en));
    // ==================================================
    // helpers
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic wcyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task automatic wr(input logic [7:0] d [8], input int n);
        host_u.buf_q = d;
        host_u.xfer(DEV_ADDR, 1'b0, n);
        chk("addr_ack", host_u.ack_ok, 1'b1);
        wcyc(4);
    endtask
    task automatic chk_codes(input logic [5:0] eq, input logic [3:0] sw, input logic [5:0] de);
        chk("eq", {eq_b, eq_a}, eq);
        chk("swing", {sw_b, sw_a}, sw);
        chk("deemph", {de_b, de_a}, de);
    endtask
    // ==================================================
    // scenarios
    task automatic t_power_on();
        chk_codes(EQ_RST, SWING_RST, DEEMPH_RST);
        chk("full_bit", full_bit_deemph, 1'b0);
        chk("lb_strap", loopback_n_cfg, 1'b0);
        chk("det_strap", detect_en, 8'h0f);
    endtask
    task automatic t_mode_high();
        wr('{8'h00, 8'h00, 8'h01, 8'hff, 8'h3f, 8'h0f, 8'h3f, 8'h07}, 8);
        chk_codes(EQ_RST, SWING_RST, DEEMPH_RST);
        chk("full_bit", full_bit_deemph, 1'b0);
        chk("indis", input_disable, INDIS_RST);
    endtask
    task automatic t_mode_low();
        mode_sel = 1'b0;
        wcyc(10);
        wr('{8'h00, 8'h00, 8'h01, 8'ha5, 8'h2a, 8'h09, 8'h3c, 8'h05}, 8);
        chk_codes(6'h2a, 4'h9, 6'h3c);
        chk("full_bit", full_bit_deemph, 1'b1);
        chk("lb_cfg", loopback_n_cfg, 1'b1);
        chk("det_en", detect_en, 8'hf0);
        // stop after byte 4 leaves the later bytes alone
        wr('{8'h00, 8'h00, 8'h01, 8'h5a, 8'h07, 8'h00, 8'h00, 8'h00}, 5);
        chk_codes(6'h07, 4'h9, 6'h3c);
        chk("indis", input_disable, 8'h5a);
    endtask
    task automatic t_read();
        logic [7:0] exp [8];
        exp = '{8'h3c, 8'h96, 8'h01, 8'h5a, 8'h07, 8'h09, 8'h3c, 8'h05};
        sig_detect = 8'h3c;
        rx50_result = 8'h96;
        wcyc(5);
        host_u.xfer(DEV_ADDR, 1'b1, 8);
        chk("rd_ack", host_u.ack_ok, 1'b1);
        for (int i = 0; i < 8; i++)
            chk("rd_byte", host_u.buf_q[i], exp[i]);
        host_u.xfer(7'h32, 1'b0, 1);
        chk("bad_addr", host_u.ack_ok, 1'b0);
    endtask
    task automatic t_squelch();
        wcyc(1);
        chk("tx_en", tx_drive_en, 8'h24);
        sig_detect = 8'hff;
        wcyc(5);
        chk("tx_en", tx_drive_en, 8'ha5);
    endtask
    task automatic t_power_down();
        power_down_n = 1'b0;
        wcyc(5);
        chk("dev_en", device_enable, 1'b0);
        chk("tx_en", tx_drive_en, 8'h00);
        chk("det_en", detect_en, 8'h00);
        power_down_n = 1'b1;
        wcyc(8);
        chk("dev_en", device_enable, 1'b1);
        chk("det_en", detect_en, 8'hf0);
    endtask
    task automatic t_chan_reset();
        int hi;
        hi = 0;
        chan_reset_n = 1'b0;
        wcyc(5);
        chk("det_rst", detect_reset, 8'hff);
        chan_reset_n = 1'b1;
        repeat (8)
        begin
            @(negedge clk);
            hi += (detect_start === 1'b1);
        end
        chk("start_pulses", 8'(hi), 8'h01);
        chk("det_rst", detect_reset, 8'h00);
    endtask
    // ==================================================
    // timeout: transfers take about 25000 cycles in all
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 60000)
        begin
            miscompares++;
            end_sim();
        end
    end
    initial
    begin
        wcyc(6);
        rst_b = 1'b1;
        wcyc(12);
        t_power_on();
        t_mode_high();
        t_mode_low();
        t_read();
        t_squelch();
        t_power_down();
        t_chan_reset();
        end_sim();
    end
endmodule
`default_nettype wire
